// >>> icm_pkg.sv
// Constants, default channel map and carrier types for the interrupt channel map.
`default_nettype none

package icm_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned  ICM_NUM_CH      = 96;
  localparam int unsigned  ICM_CH_W        = 7;
  localparam int unsigned  ICM_SRC_W       = 7;
  localparam int unsigned  ICM_VEC_W       = 7;
  localparam logic [6:0]   ICM_LAST_USABLE = 7'h5E;
  localparam logic [6:0]   ICM_SRC_NONE    = 7'h7F;
  localparam logic [6:0]   ICM_VEC_PHANTOM = 7'h00;
  localparam logic [6:0]   ICM_VEC_OFFSET  = 7'h01;

  // ----------------------------------------------------------------
  // Source line numbers; each source's line number is its default channel
  // ----------------------------------------------------------------
  localparam logic [6:0]   ICM_SRC_ESU_HIGH   = 7'h00;
  localparam logic [6:0]   ICM_SRC_TICK_CMP0  = 7'h02;
  localparam logic [6:0]   ICM_SRC_TICK_CMP1  = 7'h03;
  localparam logic [6:0]   ICM_SRC_TICK_CMP2  = 7'h04;
  localparam logic [6:0]   ICM_SRC_TICK_CMP3  = 7'h05;
  localparam logic [6:0]   ICM_SRC_TICK_OVF0  = 7'h06;
  localparam logic [6:0]   ICM_SRC_TICK_OVF1  = 7'h07;
  localparam logic [6:0]   ICM_SRC_TICK_TBASE = 7'h08;
  localparam logic [6:0]   ICM_SRC_CV1_EVENT  = 7'h0E;
  localparam logic [6:0]   ICM_SRC_CV1_GRP1   = 7'h0F;
  localparam logic [6:0]   ICM_SRC_ESU_LOW    = 7'h14;
  localparam logic [6:0]   ICM_SRC_CV1_MAG    = 7'h1F;
  localparam logic [6:0]   ICM_SRC_CV2_EVENT  = 7'h32;
  localparam logic [6:0]   ICM_SRC_CV2_GRP1   = 7'h33;
  localparam logic [6:0]   ICM_SRC_CV2_GRP2   = 7'h39;
  localparam logic [6:0]   ICM_SRC_CV2_MAG    = 7'h3B;
  localparam logic [6:0]   ICM_SRC_ET2_LVL0   = 7'h3F;
  localparam logic [6:0]   ICM_SRC_TU2_LVL0   = 7'h41;
  localparam logic [6:0]   ICM_SRC_ET2_LVL1   = 7'h49;
  localparam logic [6:0]   ICM_SRC_TU2_LVL1   = 7'h4B;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic [6:0] channel;
    logic [6:0] source;
  } icm_map_wr_s;

  typedef struct packed {
    logic       pending;
    logic [6:0] channel;
    logic [6:0] vector;
  } icm_irq_s;

  // Default source of a channel; channels with no source get the none code.
  function automatic logic [6:0] icm_default_src(input logic [6:0] ch);
    logic [6:0] src;
    src = ch;
    if (ch == 7'h01 || ch == 7'h12 || ch == 7'h20 || ch == 7'h30 || ch == 7'h34 ||
        ch == 7'h3A || ch == 7'h3E || (ch >= 7'h43 && ch <= 7'h48) ||
        (ch >= 7'h4C && ch <= 7'h4F) || (ch >= 7'h53 && ch <= 7'h57) || ch >= 7'h5A) begin
      src = ICM_SRC_NONE;
    end
    return src;
  endfunction

endpackage

`default_nettype wire

// >>> icm_channel_map.sv
// Interrupt source to request channel map with fixed lowest-number-first arbitration.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [R1] The error signaling unit high request sits on channel 0 and its low request on channel 20 after reset.
// [R2] The tick timer compares sit on channels 2 to 5, its overflows on 6 and 7 and its timebase on 8.
// [R3] The first converter event group, group 1 and magnitude compare sit on channels 14, 15 and 31.
// [R4] The second converter event group, group 1, group 2 and magnitude compare sit on 50, 51, 57 and 59.
// [R5] The second event timer levels sit on 63 and 73 and its transfer unit levels on 65 and 75.
// [R6] Vector address zero is the phantom entry, only channels 0 to 94 serve, and a vector is channel plus one.
// [R7] Among pending channels the lowest number always wins.
// [R8] A mapping write replaces the source that drives a channel.
// [R9] There are 96 channels, each with its own enable and a priority given by its number.
// [R10] Channels with no default source stay silent until a source is mapped onto them.

module icm_channel_map #(
  parameter int unsigned NUM_SRC = 96
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_arst_n,
  input  wire logic [NUM_SRC-1:0]       i_src_req,
  input  wire logic [95:0]              i_chan_en,
  input  wire icm_pkg::icm_map_wr_s     i_map,
  output var  icm_pkg::icm_irq_s        o_irq
);
  import icm_pkg::*;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // The source index is seven bits wide and 7'h7F means no source, so at most 127 sources fit.
  if (NUM_SRC < 1 || NUM_SRC > 127) begin : g_bad_src
    $error("NUM_SRC must lie between 1 and 127.");
  end

  // ----------------------------------------------------------------
  // Channel map table
  // ----------------------------------------------------------------
  logic [6:0] map_r   [ICM_NUM_CH];
  logic [6:0] map_nxt [ICM_NUM_CH];
  logic       remapped_r;
  logic       remapped_nxt;

  // A write to a channel inside the table replaces its source.
  // A write to a channel code outside the table is dropped, so it cannot corrupt a neighbour.
  always_comb begin
    for (int c = 0; c < ICM_NUM_CH; c++) begin
      map_nxt[c] = map_r[c];
    end
    remapped_nxt = remapped_r;
    if (i_map.wr && i_map.channel < ICM_CH_W'(ICM_NUM_CH)) begin
      map_nxt[i_map.channel] = i_map.source; // R8
      remapped_nxt           = 1'b1;
    end
  end

  // The table resets to the default map.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int c = 0; c < ICM_NUM_CH; c++) begin
        map_r[c] <= icm_default_src(ICM_CH_W'(c)); // R1 R2 R3 R4 R5 R10
      end
      remapped_r <= 1'b0;
    end else begin
      for (int c = 0; c < ICM_NUM_CH; c++) begin
        map_r[c] <= map_nxt[c];
      end
      remapped_r <= remapped_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Channel requests and arbitration
  // ----------------------------------------------------------------
  logic [95:0] chan_req;
  logic        win_valid;
  logic [6:0]  win_ch;

  // A channel requests when enabled, usable and fed by an active source.
  always_comb begin
    for (int c = 0; c < ICM_NUM_CH; c++) begin
      chan_req[c] = i_chan_en[c] &&                       // R9
                    (ICM_CH_W'(c) <= ICM_LAST_USABLE) &&   // R6
                    (map_r[c] != ICM_SRC_NONE) &&          // R10
                    (map_r[c] < ICM_SRC_W'(NUM_SRC)) &&
                    i_src_req[map_r[c]];
    end
  end

  // Scan from the top down so the lowest pending channel is left last.
  // A fixed order settles the winner within one clock, at the cost of any rotating fairness.
  always_comb begin
    win_valid = 1'b0;
    win_ch    = 7'h00;
    for (int c = ICM_NUM_CH - 1; c >= 0; c--) begin
      if (chan_req[c]) begin
        win_valid = 1'b1;
        win_ch    = ICM_CH_W'(c); // R7
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered dispatch output
  // ----------------------------------------------------------------
  icm_irq_s irq_r;
  icm_irq_s irq_nxt;

  // The vector points one address above the channel, or to the phantom entry.
  // An idle dispatch points at the phantom entry, so a spurious fetch lands on a safe handler.
  always_comb begin
    irq_nxt.pending = win_valid;
    irq_nxt.channel = win_ch;
    irq_nxt.vector  = win_valid ? (win_ch + ICM_VEC_OFFSET) : ICM_VEC_PHANTOM; // R6
  end

  // The output register.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_r <= '0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign o_irq = irq_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [95:0] req_d_r;
  logic [95:0] req_d_nxt;

  // Last cycle's channel requests, kept for the checks.
  always_comb begin
    req_d_nxt = chan_req;
  end

  // The delayed request register.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      req_d_r <= '0;
    end else begin
      req_d_r <= req_d_nxt;
    end
  end

  // The output register and req_d_r load at the same edge, so the checks below that read req_d_r
  // compare a dispatch with the very requests that produced it.
  a_vector_offset: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R6
    o_irq.pending |-> (o_irq.vector == o_irq.channel + ICM_VEC_OFFSET) && (o_irq.channel <= ICM_LAST_USABLE))
    else $error("Vector is not channel plus one or channel is unusable.");

  a_phantom_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R6
    !o_irq.pending |-> o_irq.vector == ICM_VEC_PHANTOM)
    else $error("Idle output does not point to the phantom entry.");

  a_lowest_wins: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R7
    o_irq.pending |-> req_d_r[o_irq.channel] && ((req_d_r & ((96'h1 << o_irq.channel) - 96'h1)) == 96'h0))
    else $error("A lower pending channel lost arbitration.");

  a_any_served: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R7
    (|chan_req) |=> o_irq.pending)
    else $error("A pending channel was not dispatched.");

  a_map_write: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R8
    (i_map.wr && i_map.channel < ICM_CH_W'(ICM_NUM_CH)) |=> map_r[$past(i_map.channel)] == $past(i_map.source))
    else $error("Mapping write did not take effect.");

  a_enable_gate: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R9
    !i_chan_en[20] |-> !chan_req[20])
    else $error("Disabled channel raised a request.");

  // Until the first mapping write the table must still hold the default map.
  a_esu_default: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R1
    !remapped_r |-> map_r[0] == ICM_SRC_ESU_HIGH && map_r[20] == ICM_SRC_ESU_LOW)
    else $error("Error signaling default map is wrong.");

  a_tick_default: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R2
    !remapped_r |-> map_r[2] == ICM_SRC_TICK_CMP0 && map_r[5] == ICM_SRC_TICK_CMP3 &&
                    map_r[7] == ICM_SRC_TICK_OVF1 && map_r[8] == ICM_SRC_TICK_TBASE)
    else $error("Tick timer default map is wrong.");

  a_cv1_default: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R3
    !remapped_r |-> map_r[14] == ICM_SRC_CV1_EVENT && map_r[15] == ICM_SRC_CV1_GRP1 && map_r[31] == ICM_SRC_CV1_MAG)
    else $error("First converter default map is wrong.");

  a_cv2_default: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R4
    !remapped_r |-> map_r[50] == ICM_SRC_CV2_EVENT && map_r[51] == ICM_SRC_CV2_GRP1 &&
                    map_r[57] == ICM_SRC_CV2_GRP2 && map_r[59] == ICM_SRC_CV2_MAG)
    else $error("Second converter default map is wrong.");

  a_et2_default: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R5
    !remapped_r |-> map_r[63] == ICM_SRC_ET2_LVL0 && map_r[73] == ICM_SRC_ET2_LVL1 &&
                    map_r[65] == ICM_SRC_TU2_LVL0 && map_r[75] == ICM_SRC_TU2_LVL1)
    else $error("Second event timer default map is wrong.");

  a_unmapped_quiet: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R10
    !remapped_r |-> !chan_req[1] && !chan_req[18] && !chan_req[95])
    else $error("Channel without a source raised a request.");

  a_tick_rest: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R2
    !remapped_r |-> map_r[3] == ICM_SRC_TICK_CMP1 && map_r[4] == ICM_SRC_TICK_CMP2 &&
                    map_r[6] == ICM_SRC_TICK_OVF0)
    else $error("Tick timer compare and overflow defaults are wrong.");

  a_pending_match: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R7
    o_irq.pending == (|req_d_r))
    else $error("Pending flag does not follow the channel requests.");

  a_disabled_quiet: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R9
    (chan_req & ~i_chan_en) == 96'h0)
    else $error("A channel with its enable low raised a request.");

  a_remap_serve: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R8
    (i_map.wr && i_map.channel <= ICM_LAST_USABLE && i_map.source < ICM_SRC_W'(NUM_SRC)) |=>
      (!i_src_req[$past(i_map.source)] || !i_chan_en[$past(i_map.channel)] || chan_req[$past(i_map.channel)]))
    else $error("Remapped source does not drive its new channel.");

endmodule

`default_nettype wire

// >>> icm_src_model.sv
// Behavioural model of the peripheral request lines that feed the channel map.
`timescale 1ns/1ps
`default_nettype none

module icm_src_model (
  input  wire logic        i_clk,
  input  wire logic [95:0] i_req_set,
  output var  logic [95:0] o_src_req
);
  // Each source changes its level on the falling edge and holds it for a whole cycle.
  initial begin
    o_src_req = '0;
    forever begin
      @(negedge i_clk);
      o_src_req <= i_req_set;
    end
  end
endmodule

`default_nettype wire

// >>> icm_channel_map_bench.sv
// Self-checking testbench for the interrupt channel map against a reference map.
`timescale 1ns/1ps
`default_nettype none

module icm_channel_map_bench;
  import icm_pkg::*;
  logic        i_clk      = 1'b0;
  logic        i_arst_n   = 1'b0;
  logic [95:0] req_set    = '0;
  logic [95:0] i_src_req;
  logic [95:0] i_chan_en  = '0;
  icm_map_wr_s i_map      = '0;
  icm_irq_s    o_irq;
  logic [6:0]  ref_map [96];
  logic [31:0] seed       = 32'hEA706D53;
  int          mismatches = 0;
  int          num_checks = 0;

  icm_src_model SRC (.i_clk(i_clk), .i_req_set(req_set), .o_src_req(i_src_req));
  icm_channel_map #(.NUM_SRC(96)) DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_src_req(i_src_req),
    .i_chan_en(i_chan_en), .i_map(i_map), .o_irq(o_irq));

  // Free-running 50 ns clock.
  initial begin
    forever #25 i_clk = ~i_clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Channels left empty by the default assignment carry the no-source code.
  function automatic logic [6:0] dflt(input int c);
    if (c == 1 || c == 18 || c == 32 || c == 48 || c == 52 || c == 58 || c == 62 || (c >= 67 && c <= 72) ||
        (c >= 76 && c <= 79) || (c >= 83 && c <= 87) || c >= 90) return 7'h7F;
    return 7'(c);
  endfunction

  // Lowest usable enabled channel whose mapped source requests wins; vector is channel plus one.
  function automatic icm_irq_s expect_irq(input logic [95:0] r, input logic [95:0] e);
    for (int c = 0; c <= 94; c++) begin
      if (e[c] && ref_map[c] != 7'h7F && r[ref_map[c]]) return '{1'b1, 7'(c), 7'(c + 1)};
    end
    return '0;
  endfunction

  task automatic check(input icm_irq_s seen, input icm_irq_s exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t irq %h expected %h", $time, seen, exp);
    end
  endtask

  // Requests and enables land on a falling edge; the answer is read one cycle later.
  task automatic step(input logic [95:0] r, input logic [95:0] e);
    @(posedge i_clk);
    #1 req_set = r;
    @(negedge i_clk);
    i_chan_en <= e;
    @(negedge i_clk);
    check(o_irq, expect_irq(r, e));
  endtask

  // A one-cycle mapping strobe; out-of-range channels leave the map alone.
  task automatic map_wr(input int ch, input logic [6:0] src);
    @(negedge i_clk);
    i_map <= '{1'b1, 7'(ch), src};
    @(negedge i_clk);
    i_map <= '0;
    if (ch < 96) ref_map[ch] = src;
  endtask

  task automatic do_reset();
    i_arst_n <= 1'b0;
    repeat (4) @(negedge i_clk);
    i_arst_n <= 1'b1;
    for (int c = 0; c < 96; c++) ref_map[c] = dflt(c);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Cuts a hang short well after the expected run of about six hundred cycles.
  initial begin
    #(50 * 5000);
    mismatches++;
    give_verdict();
  end

  // Main sequence: default map, random contention, remapping, then a reset in mid-run.
  initial begin
    do_reset();
    for (int k = 0; k < 96; k++) step(96'h1 << k, '1);
    $display("default map test done");
    repeat (200) step({xs(), xs(), xs()} & {xs(), xs(), xs()}, {xs(), xs(), xs()});
    step(~96'h1, '1);
    $display("random priority test done");
    map_wr(1, 7'h09);
    step(96'h1 << 9, '1);
    map_wr(0, ICM_SRC_NONE);
    step(96'h1, '1);
    map_wr(95, 7'h02);
    map_wr(100, 7'h00);
    step(96'h4, '1);
    step(96'h4, ~96'h4);
    $display("remap test done");
    do_reset();
    step(96'h1 << 9, 96'h2);
    step(96'h1, '1);
    $display("reset restore test done");
    give_verdict();
  end
endmodule

`default_nettype wire
